// *** core/ssp_pkg.sv ***
// Package: register map, field positions and reset values of the serial port pin block
package ssp_pkg;
    localparam int ADDR_W = 8;
    localparam int WORD_W = 16;
    localparam int NPIN = 6;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_GOUT = 8'h08;
    localparam logic [7:0] OFS_FLAG = 8'h0C;
    localparam logic [7:0] OFS_PIN = 8'h10;
    localparam logic [7:0] OFS_TX = 8'h14;
    localparam logic [7:0] OFS_RX = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;
    // Control register fields
    localparam int CTRL_ASYNC = 0;
    localparam int CTRL_CONT = 1;
    localparam int CTRL_FS_OUT = 2;
    localparam int CTRL_CLK_OUT = 3;
    localparam int CTRL_SEL = 8;
    // Flag register fields
    localparam int FLAG_VAL = 0;
    localparam int FLAG_DIR = 8;
    // Status register fields
    localparam int STAT_TX_BUSY = 0;
    localparam int STAT_RX_FULL = 1;
    // Pin indices in every pin vector
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_BCK = 3;
    localparam int PIN_RXD = 4;
    localparam int PIN_TXD = 5;
    // Writable bits and reset values
    localparam logic [31:0] CTRL_MASK = 32'h0000_3F0F;
    localparam logic [31:0] DIR_MASK = 32'h0000_003F;
    localparam logic [31:0] FLAG_MASK = 32'h0000_0303;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DIR_RST = 32'h0000_0000;
    localparam logic [31:0] GOUT_RST = 32'h0000_0000;
    localparam logic [31:0] FLAG_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** core/ssp_link_if.sv ***
// Interface: signals between the bus-clock core and the link-clock shifter
`timescale 1ns/1ps
interface ssp_link_if #(parameter int WIDTH = 16);
    logic rst_n;
    logic [WIDTH-1:0] tx_word;
    logic tx_req;
    logic tx_ack;
    logic [WIDTH-1:0] rx_word;
    logic rx_tog;
    logic fs_lvl;
    logic fs_out;
    logic sel_rx;
    logic sel_tx;
    logic gout_tx;
    logic rx_in;
    logic fs_in;
    logic tx_pin;
    modport core (output rst_n, tx_word, tx_req, fs_out, sel_rx, sel_tx, gout_tx, rx_in, fs_in,
        input tx_ack, rx_word, rx_tog, fs_lvl, tx_pin);
    modport link (input rst_n, tx_word, tx_req, fs_out, sel_rx, sel_tx, gout_tx, rx_in, fs_in,
        output tx_ack, rx_word, rx_tog, fs_lvl, tx_pin);
endinterface

// *** core/ssp_sync2.sv ***
// Two-flop level synchroniser, any width
`timescale 1ns/1ps
module ssp_sync2 #(parameter int WIDTH = 1) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // Next values, cleared while reset is low
    always_comb begin
        next_meta = rst_n ? d : '0;
        next_q = rst_n ? meta : '0;
    end

    // Register stages
    always_ff @(posedge clk) begin
        meta <= next_meta;
        q <= next_q;
    end
endmodule // ssp_sync2

// *** core/ssp_link.sv ***
// Link-clock shifter: receive and transmit shift registers and frame counter
`timescale 1ns/1ps
module ssp_link #(parameter int WIDTH = 16) (
    input wire logic link_clk,
    ssp_link_if.link lk
);
    import ssp_pkg::*;
    localparam int CW = $clog2(WIDTH);
    logic [4:0] cfg_s;
    logic [CW-1:0] cnt, next_cnt;
    logic [WIDTH-1:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh, next_rx_word;
    logic fs_q, next_fs_q, next_rx_tog, next_tx_ack, next_fs_lvl, next_tx_pin;
    logic wrap, fs_edge;

    // Configuration and request toggle into the link domain
    ssp_sync2 #(.WIDTH(5)) u_cfg (
        .clk(link_clk),
        .rst_n(lk.rst_n),
        .d({lk.gout_tx, lk.sel_tx, lk.sel_rx, lk.fs_out, lk.tx_req}),
        .q(cfg_s)
    );

    // Frame count, shifting and word hand-over
    always_comb begin
        wrap = cnt == CW'(WIDTH - 1);
        fs_edge = !cfg_s[1] && lk.fs_in && !fs_q; // Peer frame sync restarts the word
        next_fs_q = lk.fs_in;
        next_cnt = (wrap || fs_edge) ? '0 : cnt + CW'(1);
        next_rx_sh = {rx_sh[WIDTH-2:0], lk.rx_in};
        next_rx_word = lk.rx_word;
        next_rx_tog = lk.rx_tog;
        if (wrap && cfg_s[2]) begin
            next_rx_word = next_rx_sh;
            next_rx_tog = ~lk.rx_tog;
        end
        next_tx_sh = {tx_sh[WIDTH-2:0], 1'b0};
        next_tx_ack = lk.tx_ack;
        if ((wrap || fs_edge) && (cfg_s[0] != lk.tx_ack)) begin
            next_tx_sh = lk.tx_word;
            next_tx_ack = ~lk.tx_ack;
        end
        next_fs_lvl = next_cnt < CW'(WIDTH / 2); // High through the first half word
        next_tx_pin = cfg_s[3] ? next_tx_sh[WIDTH-1] : cfg_s[4];
    end

    // Link-domain registers
    always_ff @(posedge link_clk) begin
        if (!lk.rst_n) begin
            cnt <= '0;
            rx_sh <= '0;
            tx_sh <= '0;
            fs_q <= 1'b0;
            lk.rx_word <= '0;
            lk.rx_tog <= 1'b0;
            lk.tx_ack <= 1'b0;
            lk.fs_lvl <= 1'b0;
            lk.tx_pin <= 1'b0;
        end else begin
            cnt <= next_cnt;
            rx_sh <= next_rx_sh;
            tx_sh <= next_tx_sh;
            fs_q <= next_fs_q;
            lk.rx_word <= next_rx_word;
            lk.rx_tog <= next_rx_tog;
            lk.tx_ack <= next_tx_ack;
            lk.fs_lvl <= next_fs_lvl;
            lk.tx_pin <= next_tx_pin;
        end
    end
endmodule // ssp_link

// *** core/ssp_pin_mux.sv ***
// Serial port pin-function logic with AXI4-Lite registers
// Contract
// - sync mode, pin A is a serial flag
// - async mode, pin A is clock I/O
// - async mode, pin B is frame sync I/O
// - sync continuous clock, pin B is flag
// - the two flags are driven independently
// - pin C carries frame sync only
// - bit clock pin is the bit clock; the code only makes it an input, and the shifter runs on link_clk
// - receive pin feeds the receive shifter
// - transmit pin driven from transmit shifter
// - unselected pin works as general-purpose line
// - after reset all pins are inputs
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module ssp_pin_mux #(parameter int WIDTH = ssp_pkg::WORD_W) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic link_clk,
    input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_ctrl_pin_a_in,
    output logic serial_ctrl_pin_a_out,
    output logic serial_ctrl_pin_a_oe,
    input wire logic serial_ctrl_pin_b_in,
    output logic serial_ctrl_pin_b_out,
    output logic serial_ctrl_pin_b_oe,
    input wire logic serial_ctrl_pin_c_in,
    output logic serial_ctrl_pin_c_out,
    output logic serial_ctrl_pin_c_oe,
    input wire logic serial_bit_clk_pin_in,
    output logic serial_bit_clk_pin_out,
    output logic serial_bit_clk_pin_oe,
    input wire logic serial_rx_data_pin_in,
    output logic serial_rx_data_pin_out,
    output logic serial_rx_data_pin_oe,
    input wire logic serial_tx_data_pin_in,
    output logic serial_tx_data_pin_out,
    output logic serial_tx_data_pin_oe
);
    import ssp_pkg::*;
    localparam int IS_ACK = NPIN;
    localparam int IS_RXT = NPIN + 1;
    localparam int IS_FS = NPIN + 2;

    ssp_link_if #(.WIDTH(WIDTH)) lk ();

    logic [31:0] ctrl, gdir, gout, flag, next_ctrl, next_gdir, next_gout, next_flag;
    logic [WIDTH-1:0] tx_word, rx_word, next_tx_word, next_rx_word;
    logic tx_req, rx_full, rx_seen, clk_div, next_tx_req, next_rx_full, next_rx_seen, next_clk_div;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] wdata, next_wdata, next_rdata;
    logic [3:0] wstrb, next_wstrb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [NPIN-1:0] pin_oe, next_pin_oe;
    logic [NPIN-2:0] pin_out, next_pin_out;
    logic [NPIN+2:0] in_s;
    logic [NPIN-1:0] sel;
    logic async_md, tx_busy, rx_new;

    // Byte-lane merge of a write into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Pin inputs and link status into the bus domain
    ssp_sync2 #(.WIDTH(NPIN + 3)) u_in (
        .clk(aclk),
        .rst_n(aresetn),
        .d({lk.fs_lvl, lk.rx_tog, lk.tx_ack, serial_tx_data_pin_in, serial_rx_data_pin_in,
            serial_bit_clk_pin_in, serial_ctrl_pin_c_in, serial_ctrl_pin_b_in, serial_ctrl_pin_a_in}),
        .q(in_s)
    );

    // Reset into the link domain
    ssp_sync2 #(.WIDTH(1)) u_lrst (
        .clk(link_clk),
        .rst_n(1'b1),
        .d(aresetn),
        .q(lk.rst_n)
    );

    // Link-clock shifter
    ssp_link #(.WIDTH(WIDTH)) u_link (
        .link_clk(link_clk),
        .lk(lk)
    );

    // Values handed to the link domain
    assign sel = ctrl[CTRL_SEL +: NPIN];
    assign async_md = ctrl[CTRL_ASYNC];
    assign tx_busy = tx_req != in_s[IS_ACK];
    assign rx_new = in_s[IS_RXT] != rx_seen;
    assign lk.tx_word = tx_word;
    assign lk.tx_req = tx_req;
    assign lk.fs_out = ctrl[CTRL_FS_OUT];
    assign lk.sel_rx = sel[PIN_RXD];
    assign lk.sel_tx = sel[PIN_TXD];
    assign lk.gout_tx = gout[PIN_TXD];
    assign lk.rx_in = serial_rx_data_pin_in;
    assign lk.fs_in = async_md ? serial_ctrl_pin_b_in : serial_ctrl_pin_c_in;

    // Register bus: write and read channels, register effects
    always_comb begin
        next_awready = s_axi_awready;
        next_wready = s_axi_wready;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_aw_addr = aw_addr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_ctrl = ctrl;
        next_gdir = gdir;
        next_gout = gout;
        next_flag = flag;
        next_tx_word = tx_word;
        next_tx_req = tx_req;
        next_rx_word = rx_word;
        next_rx_full = rx_full;
        next_rx_seen = in_s[IS_RXT];
        next_clk_div = ~clk_div;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awready = 1'b0;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wready = 1'b0;
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
        end
        if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            unique case (aw_addr)
                OFS_CTRL: next_ctrl = merge(ctrl, wdata, wstrb) & CTRL_MASK;
                OFS_DIR: next_gdir = merge(gdir, wdata, wstrb) & DIR_MASK;
                OFS_GOUT: next_gout = merge(gout, wdata, wstrb) & DIR_MASK;
                OFS_FLAG: next_flag = merge(flag, wdata, wstrb) & FLAG_MASK;
                OFS_TX: begin
                    if (tx_busy) begin
                        next_bresp = RESP_SLVERR;
                    end else begin
                        next_tx_word = WIDTH'(merge({{(32-WIDTH){1'b0}}, tx_word}, wdata, wstrb));
                        next_tx_req = ~tx_req;
                    end
                end
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_CTRL: next_rdata = ctrl;
                OFS_DIR: next_rdata = gdir;
                OFS_GOUT: next_rdata = gout;
                OFS_FLAG: next_rdata = flag;
                OFS_PIN: next_rdata = {{(32-NPIN){1'b0}}, in_s[NPIN-1:0]};
                OFS_TX: next_rdata = {{(32-WIDTH){1'b0}}, tx_word};
                OFS_RX: begin
                    next_rdata = {{(32-WIDTH){1'b0}}, rx_word};
                    next_rx_full = 1'b0;
                end
                OFS_STAT: next_rdata = {30'h0000_0000, rx_full, tx_busy};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        // New received word; wins over a read in the same cycle
        if (rx_new) begin
            next_rx_word = lk.rx_word;
            next_rx_full = 1'b1;
        end
    end

    // Pin function selection
    always_comb begin
        next_pin_oe = gdir[NPIN-1:0];
        next_pin_out = gout[NPIN-2:0];
        if (sel[PIN_A]) begin
            if (async_md) begin
                next_pin_oe[PIN_A] = ctrl[CTRL_CLK_OUT];
                next_pin_out[PIN_A] = clk_div;
            end else begin
                next_pin_oe[PIN_A] = flag[FLAG_DIR];
                next_pin_out[PIN_A] = flag[FLAG_VAL];
            end
        end
        if (sel[PIN_B] && async_md) begin
            next_pin_oe[PIN_B] = ctrl[CTRL_FS_OUT];
            next_pin_out[PIN_B] = in_s[IS_FS];
        end else if (sel[PIN_B] && ctrl[CTRL_CONT]) begin
            next_pin_oe[PIN_B] = flag[FLAG_DIR + 1];
            next_pin_out[PIN_B] = flag[FLAG_VAL + 1];
        end
        if (sel[PIN_C]) begin
            next_pin_oe[PIN_C] = ctrl[CTRL_FS_OUT];
            next_pin_out[PIN_C] = in_s[IS_FS];
        end
        if (sel[PIN_BCK]) begin
            next_pin_oe[PIN_BCK] = 1'b0;
        end
        if (sel[PIN_RXD]) begin
            next_pin_oe[PIN_RXD] = 1'b0;
        end
        if (sel[PIN_TXD]) begin
            next_pin_oe[PIN_TXD] = 1'b1;
        end
    end

    // Bus-domain registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_addr <= '0;
            wdata <= 32'h0000_0000;
            wstrb <= 4'h0;
            ctrl <= CTRL_RST;
            gdir <= DIR_RST;
            gout <= GOUT_RST;
            flag <= FLAG_RST;
            tx_word <= '0;
            tx_req <= 1'b0;
            rx_word <= '0;
            rx_full <= 1'b0;
            rx_seen <= 1'b0;
            clk_div <= 1'b0;
            pin_oe <= '0;
            pin_out <= '0;
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            aw_addr <= next_aw_addr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            ctrl <= next_ctrl;
            gdir <= next_gdir;
            gout <= next_gout;
            flag <= next_flag;
            tx_word <= next_tx_word;
            tx_req <= next_tx_req;
            rx_word <= next_rx_word;
            rx_full <= next_rx_full;
            rx_seen <= next_rx_seen;
            clk_div <= next_clk_div;
            pin_oe <= next_pin_oe;
            pin_out <= next_pin_out;
        end
    end

    // Pin ports from their flops
    assign serial_ctrl_pin_a_out = pin_out[PIN_A];
    assign serial_ctrl_pin_a_oe = pin_oe[PIN_A];
    assign serial_ctrl_pin_b_out = pin_out[PIN_B];
    assign serial_ctrl_pin_b_oe = pin_oe[PIN_B];
    assign serial_ctrl_pin_c_out = pin_out[PIN_C];
    assign serial_ctrl_pin_c_oe = pin_oe[PIN_C];
    assign serial_bit_clk_pin_out = pin_out[PIN_BCK];
    assign serial_bit_clk_pin_oe = pin_oe[PIN_BCK];
    assign serial_rx_data_pin_out = pin_out[PIN_RXD];
    assign serial_rx_data_pin_oe = pin_oe[PIN_RXD];
    assign serial_tx_data_pin_out = lk.tx_pin; // Link-domain flop
    assign serial_tx_data_pin_oe = pin_oe[PIN_TXD];

    // Checks of pin roles
    a_flag_a_sync: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_A] && !async_md |=> pin_oe[PIN_A] == $past(flag[FLAG_DIR]) && pin_out[PIN_A] == $past(flag[FLAG_VAL]))
        else $error("pin A not a flag in sync mode");
    a_clk_a_async: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_A] && async_md |=> pin_oe[PIN_A] == $past(ctrl[CTRL_CLK_OUT]) && pin_out[PIN_A] == $past(clk_div))
        else $error("pin A not clock in async mode");
    a_fs_b_async: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_B] && async_md |=> pin_oe[PIN_B] == $past(ctrl[CTRL_FS_OUT]) && pin_out[PIN_B] == $past(in_s[IS_FS]))
        else $error("pin B not frame sync in async mode");
    a_flag_b_cont: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_B] && !async_md && ctrl[CTRL_CONT] |=> pin_oe[PIN_B] == $past(flag[FLAG_DIR + 1]))
        else $error("pin B not a flag in continuous sync mode");
    a_flags_indep: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_A] && sel[PIN_B] && !async_md && ctrl[CTRL_CONT] && flag[FLAG_VAL] != flag[FLAG_VAL + 1]
        |=> pin_out[PIN_A] != pin_out[PIN_B])
        else $error("flags not independent");
    a_fs_c_only: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_C] |=> pin_oe[PIN_C] == $past(ctrl[CTRL_FS_OUT]) && pin_out[PIN_C] == $past(in_s[IS_FS]))
        else $error("pin C not frame sync");
    a_bck_input: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_BCK] |=> !pin_oe[PIN_BCK])
        else $error("bit clock pin driven while selected");
    a_rx_input: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_RXD] |=> !pin_oe[PIN_RXD])
        else $error("receive pin driven while selected");
    a_tx_driven: assert property (@(posedge aclk) disable iff (!aresetn)
        sel[PIN_TXD] |=> pin_oe[PIN_TXD])
        else $error("transmit pin not driven");
    a_gpio_fallback: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ((pin_oe ^ $past(gdir[NPIN-1:0])) & ~$past(sel)) == '0)
        else $error("unselected pin not general purpose");
    a_reset_inputs: assert property (@(posedge aclk)
        $rose(aresetn) |-> sel == '0 && gdir[NPIN-1:0] == '0 && pin_oe == '0)
        else $error("pins not inputs after reset");
    a_reset_hiz: assert property (@(posedge aclk)
        !aresetn |=> pin_oe == '0)
        else $error("pin driven during reset");
    c_async_clk: cover property (@(posedge aclk) disable iff (!aresetn) sel[PIN_A] && async_md && pin_oe[PIN_A]);
    c_rx_word: cover property (@(posedge aclk) disable iff (!aresetn) $rose(rx_full));
    c_tx_taken: cover property (@(posedge aclk) disable iff (!aresetn) $fell(tx_busy));
    c_flags: cover property (@(posedge aclk) disable iff (!aresetn) pin_oe[PIN_A] && pin_oe[PIN_B] && !async_md);
endmodule // ssp_pin_mux

// *** verif/ssp_peer.sv ***
// Far-side serial peer: frames words into the port and records transmit bits
`timescale 1ns/1ps
module ssp_peer (
    input wire logic link_clk,
    input wire logic tx_pin,
    input wire logic go,
    input wire logic [15:0] word,
    output logic rx_pin = 1'b0,
    output logic fs_pin = 1'b0,
    output logic [63:0] seen = 64'h0
);
    int n = -1;
    // Transmit history, newest bit lowest
    always @(posedge link_clk) seen <= {seen[62:0], tx_pin};
    // One frame pulse, then the word MSB first, repeated while go holds
    always @(negedge link_clk) begin
        if (n < 0) begin
            fs_pin <= go;
            if (go) n <= 15;
            else rx_pin <= ~rx_pin; // Idle line never shows a stale bit
        end else begin
            fs_pin <= 1'b0;
            rx_pin <= word[n];
            n <= (n == 0) ? (go ? 15 : -1) : n - 1;
        end
    end
endmodule // ssp_peer

// *** verif/sync_serial_port_pin_function_tb_top.sv ***
// Testbench for the serial port pin-function block
`timescale 1ns/1ps
module sync_serial_port_pin_function_tb_top;
    import ssp_pkg::*;
    logic aclk = 1'b0, link_clk = 1'b0, aresetn = 1'b0, go = 1'b0, ext_a = 1'b1, ext_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, oe, out, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_ext, fs_ext;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic serial_ctrl_pin_a_in, serial_ctrl_pin_a_out, serial_ctrl_pin_a_oe;
    logic serial_ctrl_pin_b_in, serial_ctrl_pin_b_out, serial_ctrl_pin_b_oe;
    logic serial_ctrl_pin_c_in, serial_ctrl_pin_c_out, serial_ctrl_pin_c_oe;
    logic serial_bit_clk_pin_in, serial_bit_clk_pin_out, serial_bit_clk_pin_oe;
    logic serial_rx_data_pin_in, serial_rx_data_pin_out, serial_rx_data_pin_oe;
    logic serial_tx_data_pin_in, serial_tx_data_pin_out, serial_tx_data_pin_oe;
    logic [15:0] word = 16'hA5C3;
    logic [63:0] seen;
    int num_errors = 0, n_compared = 0, cyc = 0;
    // Bus clock, then link clock offset in phase
    always #50 aclk = ~aclk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    // Pin vectors and resolved pin levels
    assign oe = {26'h0, serial_tx_data_pin_oe, serial_rx_data_pin_oe, serial_bit_clk_pin_oe,
        serial_ctrl_pin_c_oe, serial_ctrl_pin_b_oe, serial_ctrl_pin_a_oe};
    assign out = {26'h0, serial_tx_data_pin_out, serial_rx_data_pin_out, serial_bit_clk_pin_out,
        serial_ctrl_pin_c_out, serial_ctrl_pin_b_out, serial_ctrl_pin_a_out};
    assign serial_ctrl_pin_a_in = oe[0] ? out[0] : ext_a;
    assign serial_ctrl_pin_b_in = oe[1] ? out[1] : ext_b;
    assign serial_ctrl_pin_c_in = oe[2] ? out[2] : fs_ext;
    assign serial_bit_clk_pin_in = oe[3] ? out[3] : link_clk;
    assign serial_rx_data_pin_in = oe[4] ? out[4] : rx_ext;
    assign serial_tx_data_pin_in = oe[5] ? out[5] : 1'b1;
    ssp_pin_mux u_dut (.*);
    ssp_peer u_peer (.link_clk(link_clk), .tx_pin(serial_tx_data_pin_in), .go(go), .word(word),
        .rx_pin(rx_ext), .fs_pin(fs_ext), .seen(seen));
    task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
        n_compared++;
        if (sv !== ev) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, sv, ev);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
        do @(negedge aclk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic settle(input int k);
        repeat (k) @(negedge aclk);
    endtask
    task automatic t_reset();
        settle(3);
        chk(oe, 32'h0);
        @(posedge aclk);
        @(posedge aclk);
        aresetn <= 1'b1;
        settle(3);
        chk(oe, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_gpio();
        wr(OFS_DIR, 32'h3F, RESP_OKAY);
        wr(OFS_GOUT, 32'h2D, RESP_OKAY);
        settle(6);
        chk(oe, 32'h3F);
        chk(out, 32'h2D);
        wr(OFS_DIR, 32'h0, RESP_OKAY);
        settle(4);
        rd(OFS_PIN, RESP_OKAY);
        chk(d & 32'h27, 32'h21);
        wr(OFS_PIN, 32'h3F, RESP_SLVERR);
        rd(8'hF0, RESP_SLVERR);
        chk(d, 32'h0);
        $display("test gpio done");
    endtask
    task automatic t_sync();
        // Continuous clock, pins A and B on serial function, both flags driven
        wr(OFS_CTRL, 32'h0302, RESP_OKAY);
        wr(OFS_FLAG, 32'h0301, RESP_OKAY);
        settle(3);
        chk(oe & 32'h3, 32'h3);
        chk(out & 32'h3, 32'h1);
        wr(OFS_FLAG, 32'h0102, RESP_OKAY);
        settle(3);
        chk(oe & 32'h3, 32'h1);
        chk(out & 32'h1, 32'h0);
        $display("test sync flags done");
    endtask
    task automatic t_async();
        logic a1;
        wr(OFS_CTRL, 32'h0309, RESP_OKAY);
        settle(3);
        chk(oe & 32'h3, 32'h1);
        a1 = out[0];
        settle(1);
        chk({31'h0, a1 ^ out[0]}, 32'h1);
        $display("test async done");
    endtask
    task automatic t_rx();
        wr(OFS_CTRL, 32'h1C02, RESP_OKAY);
        @(posedge aclk);
        go <= 1'b1;
        settle(20);
        chk(oe & 32'h1C, 32'h0);
        rd(OFS_STAT, RESP_OKAY);
        chk(d & 32'h2, 32'h2);
        rd(OFS_RX, RESP_OKAY);
        chk(d, {16'h0, word});
        go <= 1'b0;
        $display("test receive done");
    endtask
    task automatic t_tx();
        logic f, hi, lo;
        f = 1'b0;
        hi = 1'b0;
        lo = 1'b0;
        wr(OFS_CTRL, 32'h2406, RESP_OKAY);
        wr(OFS_TX, 32'h96E1, RESP_OKAY);
        // Driven frame sync on pin C must show both levels
        repeat (14) begin
            @(negedge aclk);
            hi |= out[2];
            lo |= !out[2];
        end
        chk({30'h0, hi, lo}, 32'h3);
        chk(oe & 32'h24, 32'h24);
        for (int i = 0; i <= 48; i++) if (seen[i+:16] === 16'h96E1) f = 1'b1;
        chk({31'h0, f}, 32'h1);
        $display("test transmit done");
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        t_reset();
        t_gpio();
        t_sync();
        t_async();
        t_rx();
        t_tx();
        test_done();
    end
endmodule // sync_serial_port_pin_function_tb_top
